// ===== pcr_params.svh
// Offsets, field positions, reset values and timing counts of the PHY control register
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// =====================================================================
// Register location
`define PCR_REG_ADDR        5'h19
`define PCR_REG_W           16

// =====================================================================
// Field positions
`define PCR_B_AUTO_XOVER    15
`define PCR_B_FORCE_XOVER   14
`define PCR_B_PAUSE_RX      13
`define PCR_B_PAUSE_TX      12
`define PCR_B_ERR_INJECT    11
`define PCR_B_LONG_SEQ      10
`define PCR_B_ST_PASS       9
`define PCR_B_ST_RUN        8
`define PCR_B_STRETCH_BYP   7
`define PCR_B_RESERVED      6
`define PCR_B_LED_MODE      5
`define PCR_ADDR_HI         4
`define PCR_ADDR_LO         0

// =====================================================================
// Reset values of all fields, strap fields included until the strap load
`define PCR_RST_BIT         1'b0
`define PCR_RST_ADDR        5'h00
`define PCR_RST_WORD        16'h0000

// =====================================================================
// Timing
`define PCR_CLK_MHZ         100
`define PCR_STRETCH_US      50000
`define PCR_BLINK_US        50000
`define PCR_STRETCH_CYC     (`PCR_STRETCH_US * `PCR_CLK_MHZ)
`define PCR_BLINK_CYC       (`PCR_BLINK_US * `PCR_CLK_MHZ)

`endif

// ===== pcr_pkg.sv
// Types shared by the PHY control register files
`default_nettype none
package pcr_pkg;
    typedef logic [15:0] pcr_word_t;
    typedef logic [4:0]  pcr_addr_t;
    typedef logic [1:0]  pcr_adv_t;

    typedef enum logic [1:0] {
        PCR_ST_WAIT0 = 2'b00,
        PCR_ST_WAIT1 = 2'b01,
        PCR_ST_LOAD  = 2'b10,
        PCR_ST_RUN   = 2'b11
    } pcr_state_e;
endpackage
`default_nettype wire

// ===== pcr_led.sv
// LED driver with pulse stretching, blink and bypass
`include "pcr_params.svh"
`default_nettype none
module pcr_led #(
    parameter int unsigned STRETCH_CYC = `PCR_STRETCH_CYC,
    parameter int unsigned BLINK_CYC   = `PCR_BLINK_CYC
) (
    input  wire logic clk_sys,          // System clock
    input  wire logic arst_n,           // Async reset
    input  wire logic clk_en,           // State freeze when low
    input  wire logic stretch_bypass,   // Follow raw indication
    input  wire logic mode_select,      // 1 link only, 0 link plus activity
    input  wire logic link_good,        // Good link
    input  wire logic activity,         // Activity pulse
    input  wire logic speed_100,        // 100 Mb/s operation
    output var  logic link_indicator,   // Link LED
    output var  logic speed_indicator   // Speed LED
);
    localparam int SW = $clog2(STRETCH_CYC + 1);
    localparam int BW = $clog2(BLINK_CYC + 1);

    logic [SW-1:0] act_cnt_q, act_cnt_d;
    logic [BW-1:0] blink_cnt_q, blink_cnt_d;
    logic          blink_q, blink_d;
    logic          link_q, link_d;
    logic          speed_q, speed_d;
    logic          stretched;

    // =================================================================
    // Stretch and blink
    always_comb begin
        stretched   = activity || (act_cnt_q != '0);
        act_cnt_d   = act_cnt_q;
        blink_cnt_d = blink_cnt_q;
        blink_d     = blink_q;
        if (activity) begin
            act_cnt_d = SW'(STRETCH_CYC - 1);
        end else if (act_cnt_q != '0) begin
            act_cnt_d = act_cnt_q - SW'(1);
        end
        if (!stretched) begin
            blink_cnt_d = '0;
            blink_d     = 1'b0;
        end else if (blink_cnt_q == BW'(BLINK_CYC - 1)) begin
            blink_cnt_d = '0;
            blink_d     = !blink_q;
        end else begin
            blink_cnt_d = blink_cnt_q + BW'(1);
        end
        if (mode_select) begin
            link_d = link_good;
        end else if (stretch_bypass) begin
            link_d = link_good && !activity;
        end else begin
            link_d = link_good && !(stretched && blink_q);
        end
        speed_d = speed_100;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            act_cnt_q   <= '0;
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
            link_q      <= 1'b0;
            speed_q     <= 1'b0;
        end else if (clk_en) begin
            act_cnt_q   <= act_cnt_d;
            blink_cnt_q <= blink_cnt_d;
            blink_q     <= blink_d;
            link_q      <= link_d;
            speed_q     <= speed_d;
        end
    end

    assign link_indicator  = link_q;
    assign speed_indicator = speed_q;

    // =================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n || !clk_en);

    a_mode1_link: assert property (mode_select |=> link_indicator == $past(link_good))
        else $error("Link LED does not follow link in first mode");
    a_bypass_direct: assert property (stretch_bypass && !mode_select && link_good && activity
        |=> !link_indicator)
        else $error("Bypassed link LED not off during activity");
    a_mode2_idle: assert property (!mode_select && link_good && !activity
        && act_cnt_q == '0 |=> link_indicator)
        else $error("Link LED not steady on without activity");
    a_speed_led: assert property (1'b1 |=> speed_indicator == $past(speed_100))
        else $error("Speed LED does not follow speed");
endmodule
`default_nettype wire

// ===== pcr_top.sv
// PHY control register: crossover, pause result, self-test and LED control
//
// Behaviour
// - Bit 15 enables automatic crossover; strap reset value; read-write.
// - Bit 14 forces pairs crossed; resets to zero.
// - Read-only bit 13: pause receive, resolved, only for full duplex result.
// - Read-only bit 12: pause transmit, resolved, only for full duplex result.
// - Writing 1 to bit 11 injects one self-test error, then clears.
// - Bit 8 runs self-test, bit 10 picks sequence, bit 9 latched pass.
// - Bit 7 bypasses LED stretching so LEDs follow raw indication.
// - LED mode 1: link LED on with good link, off otherwise.
// - LED mode 2: link LED on with good link, blinks on activity.
// - Speed LED on at 100 Mb/s, off at 10 Mb/s, both modes.
// - Bits 4:0 hold the read-write management address, strap reset value.
`include "pcr_params.svh"
`default_nettype none
module pcr_top
    import pcr_pkg::*;
#(
    parameter int unsigned STRETCH_CYC = `PCR_STRETCH_CYC,
    parameter int unsigned BLINK_CYC   = `PCR_BLINK_CYC
) (
    input  wire logic            clk_sys,                 // System clock
    input  wire logic            arst_n,                  // Async reset
    input  wire logic            clk_en,                  // State freeze when low
    input  wire pcr_pkg::pcr_addr_t reg_addr,             // Register address
    input  wire logic            reg_wr,                  // Write strobe
    input  wire logic            reg_rd,                  // Read strobe
    input  wire pcr_pkg::pcr_word_t reg_wdata,            // Write data
    output var  pcr_pkg::pcr_word_t reg_rdata,            // Read data
    output var  logic            reg_rvalid,              // Read data valid
    output var  logic            cfg_ready,               // Straps loaded
    input  wire logic            strap_auto_crossover,    // Strap pin
    input  wire logic            strap_led_mode,          // Strap pin
    input  wire pcr_pkg::pcr_addr_t strap_port_address,   // Strap pins
    input  wire pcr_pkg::pcr_adv_t local_advertisement,   // Local adv bits 11:10
    input  wire pcr_pkg::pcr_adv_t partner_advertisement, // Partner adv bits 11:10
    input  wire logic            an_complete,             // Negotiation done
    input  wire logic            hcd_full_duplex,         // Common mode is full duplex
    input  wire logic            self_test_error,         // Checker mismatch pulse
    input  wire logic            link_good,               // Good link
    input  wire logic            activity,                // Activity pulse
    input  wire logic            speed_100,               // 100 Mb/s operation
    output var  logic            auto_crossover_enable,   // Crossover enable
    output var  logic            force_crossover,         // Forced crossed pairs
    output var  logic            pause_rx_enable,         // Pause receive result
    output var  logic            pause_tx_enable,         // Pause transmit result
    output var  logic            self_test_error_inject,  // One-cycle inject pulse
    output var  logic            self_test_long_sequence, // 15-bit sequence
    output var  logic            self_test_pass,          // Latched pass
    output var  logic            self_test_run,           // Self-test running
    output var  logic            led_stretch_bypass,      // LED bypass
    output var  logic            led_mode_select,         // LED mode
    output var  pcr_pkg::pcr_addr_t port_mgmt_address,    // Management address
    output var  logic            link_indicator,          // Link LED
    output var  logic            speed_indicator          // Speed LED
);
    import pcr_pkg::*;

    function automatic logic addr_hit(input pcr_addr_t a);
        addr_hit = (a == `PCR_REG_ADDR);
    endfunction

    // =================================================================
    // Strap synchroniser and load sequence
    logic [6:0] strap_s1_q, strap_s2_q;
    pcr_state_e st_q, st_d;
    logic       wr_hit;
    logic       ready_q, ready_d;

    always_comb begin
        case (st_q)
            PCR_ST_WAIT0: st_d = PCR_ST_WAIT1;
            PCR_ST_WAIT1: st_d = PCR_ST_LOAD;
            PCR_ST_LOAD:  st_d = PCR_ST_RUN;
            PCR_ST_RUN:   st_d = PCR_ST_RUN;
            default:      st_d = PCR_ST_WAIT0;
        endcase
        wr_hit = reg_wr && addr_hit(reg_addr) && (st_q == PCR_ST_RUN);
        // Registered copy so the ready output comes from a flop
        ready_d = (st_d == PCR_ST_RUN);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_s1_q <= 7'h00;
            strap_s2_q <= 7'h00;
            st_q       <= PCR_ST_WAIT0;
            ready_q    <= 1'b0;
        end else if (clk_en) begin
            strap_s1_q <= {strap_auto_crossover, strap_led_mode, strap_port_address};
            strap_s2_q <= strap_s1_q;
            st_q       <= st_d;
            ready_q    <= ready_d;
        end
    end

    // =================================================================
    // Register fields
    logic      autox_q, autox_d, force_q, force_d, inject_q, inject_d;
    logic      long_q, long_d, run_q, run_d, pass_q, pass_d;
    logic      byp_q, byp_d, mode_q, mode_d, prx_q, prx_d, ptx_q, ptx_d;
    pcr_addr_t addr_q, addr_d;
    pcr_word_t rdata_q, rdata_d, word;
    logic      rvalid_q, rvalid_d;
    logic      la, ld, pa, pd;

    always_comb begin
        autox_d  = autox_q;
        force_d  = force_q;
        long_d   = long_q;
        run_d    = run_q;
        byp_d    = byp_q;
        mode_d   = mode_q;
        addr_d   = addr_q;
        inject_d = 1'b0;
        if (st_q == PCR_ST_LOAD) begin
            autox_d = strap_s2_q[6];
            mode_d  = strap_s2_q[5];
            addr_d  = strap_s2_q[4:0];
        end else if (wr_hit) begin
            autox_d  = reg_wdata[`PCR_B_AUTO_XOVER];
            force_d  = reg_wdata[`PCR_B_FORCE_XOVER];
            inject_d = reg_wdata[`PCR_B_ERR_INJECT];
            long_d   = reg_wdata[`PCR_B_LONG_SEQ];
            run_d    = reg_wdata[`PCR_B_ST_RUN];
            byp_d    = reg_wdata[`PCR_B_STRETCH_BYP];
            mode_d   = reg_wdata[`PCR_B_LED_MODE];
            addr_d   = reg_wdata[`PCR_ADDR_HI:`PCR_ADDR_LO];
        end
        // Pass set at start, latched low on error, low while stopped
        if (!run_d) begin
            pass_d = 1'b0;
        end else if (!run_q) begin
            pass_d = 1'b1;
        end else begin
            pass_d = pass_q && !self_test_error;
        end
        // Pause resolution; [0] symmetric, [1] asymmetric
        la    = local_advertisement[0];
        ld    = local_advertisement[1];
        pa    = partner_advertisement[0];
        pd    = partner_advertisement[1];
        prx_d = an_complete && hcd_full_duplex
                && ((la && pa) || (la && ld && !pa && pd));
        ptx_d = an_complete && hcd_full_duplex
                && ((la && pa) || (!la && ld && pa && pd));
        word  = {autox_q, force_q, prx_q, ptx_q, inject_q, long_q, pass_q, run_q,
                 byp_q, 1'b0, mode_q, addr_q};
        rvalid_d = reg_rd;
        rdata_d  = (reg_rd && addr_hit(reg_addr)) ? word : `PCR_RST_WORD;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            autox_q  <= `PCR_RST_BIT;
            force_q  <= `PCR_RST_BIT;
            inject_q <= `PCR_RST_BIT;
            long_q   <= `PCR_RST_BIT;
            run_q    <= `PCR_RST_BIT;
            pass_q   <= `PCR_RST_BIT;
            byp_q    <= `PCR_RST_BIT;
            mode_q   <= `PCR_RST_BIT;
            prx_q    <= `PCR_RST_BIT;
            ptx_q    <= `PCR_RST_BIT;
            addr_q   <= `PCR_RST_ADDR;
            rdata_q  <= `PCR_RST_WORD;
            rvalid_q <= 1'b0;
        end else if (clk_en) begin
            autox_q  <= autox_d;
            force_q  <= force_d;
            inject_q <= inject_d;
            long_q   <= long_d;
            run_q    <= run_d;
            pass_q   <= pass_d;
            byp_q    <= byp_d;
            mode_q   <= mode_d;
            prx_q    <= prx_d;
            ptx_q    <= ptx_d;
            addr_q   <= addr_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata               = rdata_q;
    assign reg_rvalid              = rvalid_q;
    assign cfg_ready               = ready_q;
    assign auto_crossover_enable   = autox_q;
    assign force_crossover         = force_q;
    assign pause_rx_enable         = prx_q;
    assign pause_tx_enable         = ptx_q;
    assign self_test_error_inject  = inject_q;
    assign self_test_long_sequence = long_q;
    assign self_test_pass          = pass_q;
    assign self_test_run           = run_q;
    assign led_stretch_bypass      = byp_q;
    assign led_mode_select         = mode_q;
    assign port_mgmt_address       = addr_q;

    // =================================================================
    // LED driver
    pcr_led #(
        .STRETCH_CYC (STRETCH_CYC),
        .BLINK_CYC   (BLINK_CYC)
    ) u_led (
        .clk_sys         (clk_sys),
        .arst_n          (arst_n),
        .clk_en          (clk_en),
        .stretch_bypass  (byp_q),
        .mode_select     (mode_q),
        .link_good       (link_good),
        .activity        (activity),
        .speed_100       (speed_100),
        .link_indicator  (link_indicator),
        .speed_indicator (speed_indicator)
    );

    // =================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n || !clk_en);

    sequence s_strap_load;
        st_q == PCR_ST_LOAD;
    endsequence
    sequence s_fail_seen;
        self_test_run && self_test_pass && self_test_error && !wr_hit;
    endsequence

    a_strap_load: assert property (s_strap_load |=> port_mgmt_address == $past(strap_s2_q[4:0])
        && led_mode_select == $past(strap_s2_q[5]))
        else $error("Strap levels not loaded at reset end");
    a_autox_write: assert property (wr_hit |=> auto_crossover_enable == $past(reg_wdata[15]))
        else $error("Crossover enable not written");
    a_force_write: assert property (wr_hit |=> force_crossover == $past(reg_wdata[14]))
        else $error("Forced crossover not written");
    a_pause_rx_half: assert property (!hcd_full_duplex |=> !pause_rx_enable)
        else $error("Pause receive set without full duplex");
    a_pause_tx_sym: assert property (an_complete && hcd_full_duplex && local_advertisement == 2'h1
        && partner_advertisement == 2'h1 |=> pause_tx_enable && pause_rx_enable)
        else $error("Symmetric pause not resolved");
    a_inject_pulse: assert property (wr_hit && reg_wdata[11]
        |=> self_test_error_inject ##1 !self_test_error_inject)
        else $error("Error inject is not a single pulse");
    a_pass_stop: assert property (!self_test_run |-> !self_test_pass)
        else $error("Pass flag set while stopped");
    a_pass_latch: assert property (s_fail_seen |=> !self_test_pass [*2])
        else $error("Fail not latched");
    a_addr_write: assert property (wr_hit |=> port_mgmt_address == $past(reg_wdata[4:0]))
        else $error("Management address not written");
endmodule
`default_nettype wire

// ===== pcr_station.sv
// Station management model driving the PHY control register port
`default_nettype none
module pcr_station (
    input  wire logic               clk_sys,    // System clock
    output var  pcr_pkg::pcr_addr_t reg_addr,   // Register address
    output var  logic               reg_wr,     // Write strobe
    output var  logic               reg_rd,     // Read strobe
    output var  pcr_pkg::pcr_word_t reg_wdata,  // Write data
    input  wire pcr_pkg::pcr_word_t reg_rdata,  // Read data
    input  wire logic               reg_rvalid  // Read data valid
);
    timeunit 1ns;
    timeprecision 100ps;
    import pcr_pkg::*;

    int unsigned idle_cyc   = 0;     // Idle cycles before each request
    time         last_end   = 0;     // Time the last request was released
    logic        an_enabled = 1'b1;  // Auto-negotiation state seen by station

    initial begin
        reg_addr  = 5'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // =========================================================
    // Requests start just after an edge and last one edge
    task automatic pause_req();
        // Let an edge pass before reusing a just released strobe
        if ($time == last_end) begin
            @(posedge clk_sys);
            #1;
        end
        repeat (idle_cyc) begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    task automatic wr(input pcr_addr_t a, input pcr_word_t d);
        pcr_word_t v;
        v = d;
        v[6] = 1'b0;
        if (an_enabled !== 1'b1) begin
            v[15] = 1'b0;
        end
        pause_req();
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~v;
        last_end  = $time;
    endtask

    task automatic rd(input pcr_addr_t a, output pcr_word_t d, output logic ok);
        d  = 16'h0000;
        ok = 1'b0;
        pause_req();
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        last_end = $time;
        for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
            if (reg_rvalid === 1'b1) begin
                d  = reg_rdata;
                ok = 1'b1;
            end else begin
                @(posedge clk_sys);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== tb_pcr_top.sv
// Self-checking bench for the PHY control register
`default_nettype none
`include "pcr_params.svh"
module tb_pcr_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pcr_pkg::*;

    localparam int unsigned STRETCH = 8;
    localparam int unsigned BLINK   = 4;
    localparam pcr_addr_t   RA      = `PCR_REG_ADDR;

    logic      clk_sys = 1'b0;
    logic      arst_n, clk_en, reg_wr, reg_rd, reg_rvalid, cfg_ready;
    pcr_addr_t reg_addr, strap_port_address, port_mgmt_address;
    pcr_word_t reg_wdata, reg_rdata;
    logic      strap_auto_crossover, strap_led_mode, an_complete, hcd_full_duplex;
    pcr_adv_t  local_advertisement, partner_advertisement;
    logic      self_test_error, link_good, activity, speed_100;
    logic      auto_crossover_enable, force_crossover, pause_rx_enable, pause_tx_enable;
    logic      self_test_error_inject, self_test_long_sequence, self_test_pass;
    logic      self_test_run, led_stretch_bypass, led_mode_select;
    logic      link_indicator, speed_indicator;
    int        num_errors = 0;
    int        n_tests    = 0;

    always #5 clk_sys = ~clk_sys;

    pcr_top #(.STRETCH_CYC(STRETCH), .BLINK_CYC(BLINK)) uut (
        .clk_sys, .arst_n, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .cfg_ready, .strap_auto_crossover, .strap_led_mode,
        .strap_port_address, .local_advertisement, .partner_advertisement,
        .an_complete, .hcd_full_duplex, .self_test_error, .link_good, .activity,
        .speed_100, .auto_crossover_enable, .force_crossover, .pause_rx_enable,
        .pause_tx_enable, .self_test_error_inject, .self_test_long_sequence,
        .self_test_pass, .self_test_run, .led_stretch_bypass, .led_mode_select,
        .port_mgmt_address, .link_indicator, .speed_indicator
    );

    pcr_station stn (
        .clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid
    );

    // =========================================================
    // Helpers
    task automatic close_out();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input pcr_word_t got, input pcr_word_t exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rchk(input pcr_addr_t a, input pcr_word_t e);
        pcr_word_t d;
        logic      ok;
        stn.rd(a, d, ok);
        if (ok !== 1'b1) begin
            num_errors++;
            close_out();
        end
        chk(d, e);
    endtask

    task automatic boot(input logic early);
        arst_n = 1'b0;
        cyc(3);
        chk(reg_rdata, 16'h0000);
        chk(port_mgmt_address, 5'h00);
        arst_n = 1'b1;
        if (early) begin
            stn.wr(RA, 16'h0000);
        end
        for (int i = 0; i < 10 && cfg_ready !== 1'b1; i++) begin
            cyc(1);
        end
        if (cfg_ready !== 1'b1) begin
            num_errors++;
            close_out();
        end
    endtask

    // =========================================================
    // Main sequence
    initial begin
        logic la, ld, pa, pd;
        int   offs;
        clk_en = 1'b1;
        strap_auto_crossover = 1'b1;
        strap_led_mode = 1'b1;
        strap_port_address = 5'h15;
        local_advertisement = 2'b00;
        partner_advertisement = 2'b00;
        an_complete = 1'b0;
        hcd_full_duplex = 1'b0;
        self_test_error = 1'b0;
        link_good = 1'b0;
        activity = 1'b0;
        speed_100 = 1'b0;
        boot(1'b1);
        rchk(RA, 16'h8035);
        chk(port_mgmt_address, 5'h15);
        chk(auto_crossover_enable, 1'b1);
        stn.wr(RA, 16'hFFFF);
        chk(self_test_error_inject, 1'b1);
        cyc(1);
        chk(self_test_error_inject, 1'b0);
        rchk(RA, 16'hC7BF);
        chk(force_crossover, 1'b1);
        chk(self_test_long_sequence, 1'b1);
        chk(led_stretch_bypass, 1'b1);
        chk(port_mgmt_address, 5'h1F);
        stn.idle_cyc = 2;
        stn.wr(5'h18, 16'h0000);
        rchk(5'h18, 16'h0000);
        rchk(RA, 16'hC7BF);
        stn.idle_cyc = 0;
        self_test_error = 1'b1;
        cyc(1);
        self_test_error = 1'b0;
        cyc(4);
        chk(self_test_pass, 1'b0);
        stn.wr(RA, 16'h0000);
        rchk(RA, 16'h0000);
        chk(force_crossover, 1'b0);
        clk_en = 1'b0;
        stn.wr(RA, 16'h4000);
        clk_en = 1'b1;
        chk(force_crossover, 1'b0);
        stn.an_enabled = 1'b0;
        stn.wr(RA, 16'h8000);
        stn.an_enabled = 1'b1;
        chk(auto_crossover_enable, 1'b0);
        stn.wr(RA, 16'h0100);
        rchk(RA, 16'h0300);
        stn.wr(RA, 16'h0000);
        for (int i = 0; i < 64; i++) begin
            {an_complete, hcd_full_duplex, partner_advertisement, local_advertisement} = i[5:0];
            cyc(2);
            {ld, la} = local_advertisement;
            {pd, pa} = partner_advertisement;
            chk(pause_rx_enable, an_complete & hcd_full_duplex
                & ((la & pa) | (la & ld & !pa & pd)));
            chk(pause_tx_enable, an_complete & hcd_full_duplex
                & ((la & pa) | (!la & ld & pa & pd)));
        end
        rchk(RA, 16'h3000);
        stn.wr(RA, 16'h0020);
        link_good = 1'b1;
        speed_100 = 1'b1;
        activity = 1'b1;
        cyc(2);
        chk(link_indicator, 1'b1);
        chk(speed_indicator, 1'b1);
        link_good = 1'b0;
        speed_100 = 1'b0;
        cyc(2);
        chk(link_indicator, 1'b0);
        chk(speed_indicator, 1'b0);
        link_good = 1'b1;
        speed_100 = 1'b1;
        stn.wr(RA, 16'h0080);
        cyc(2);
        chk(link_indicator, 1'b0);
        activity = 1'b0;
        cyc(2);
        chk(link_indicator, 1'b1);
        chk(speed_indicator, 1'b1);
        stn.wr(RA, 16'h0000);
        activity = 1'b1;
        cyc(1);
        activity = 1'b0;
        offs = 0;
        for (int k = 0; k < 14; k++) begin
            cyc(1);
            if (link_indicator === 1'b0) begin
                offs++;
            end
        end
        chk(offs > 0, 1'b1);
        cyc(20);
        chk(link_indicator, 1'b1);
        strap_auto_crossover = 1'b0;
        strap_led_mode = 1'b0;
        strap_port_address = 5'h0A;
        boot(1'b0);
        rchk(RA, 16'h300A);
        chk(led_mode_select, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
